// File: watchdog_lock_sync_status.sv
// Watchdog control and status registers: configuration lock, change protection,
// synchronisation-busy tracking and restart synchronisation, behind an APB slave.
// Assumes wdtTick is a one-cycle pulse per watchdog clock period, synchronous to clk_sys,
// and that ccpUnlock is high while the processor's unlock window is open.
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_lock_sync_defines.svh"

// Summary of operation
// (R1) Codes 0x6 and 0x7 decode to 256 and 512 watchdog clock periods.
// (R2) Codes 0x8 to 0xB decode to 1K, 2K, 4K and 8K watchdog clock periods.
// (R3) Software must not use codes above 0xB; they are flagged reserved.
// (R4) Status at index 0x01: lock in bit 7, busy in bit 0, both reset zero.
// (R5) While locked, writes to the control register are ignored.
// (R6) Software can only set the lock; writing zero outside debug changes nothing.
// (R7) The lock clears only while the processor is in debug mode.
// (R8) A nonzero boot period field sets the lock automatically.
// (R9) Setting the lock needs the change-protection unlock first.
// (R10) A control write raises the busy flag while it crosses to the watchdog clock.
// (R11) The busy flag drops by itself once the crossing has finished.
// (R12) The busy flag is read-only and reads without any unlock.
// (R13) Software must not write the control register while busy reads one.
// (R14) Protected bits change only inside the unlock window; otherwise they stay unchanged.
// (R15) A restart takes one to two watchdog clocks; restarts meanwhile are ignored.
// (R16) Period codes 0x1 to 0xB enable the watchdog; window codes 0x1 to 0xB select the closed window.
// (R17) Status bits 6 to 1 read zero and ignore writes.
module watchdog_lock_sync_status (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wdtTick,
    input wire logic ccpUnlock,
    input wire logic debugMode,
    input wire watchdog_lock_sync_pkg::control_word_t bootControl,
    input wire logic restartReq,
    output watchdog_lock_sync_pkg::timeout_code_t activePeriod,
    output watchdog_lock_sync_pkg::timeout_code_t activeWindow,
    output watchdog_lock_sync_pkg::timeout_cycles_t periodCycles,
    output watchdog_lock_sync_pkg::timeout_cycles_t windowCycles,
    output logic watchdogEnabled,
    output logic windowModeEnabled,
    output logic codeReserved,
    output logic configLocked,
    output logic sync_in_progress_flag,
    output logic restartSynced
);
    import watchdog_lock_sync_pkg::*;

    // Register index, or all ones for a misaligned address
    function automatic logic [9:0] regIndex(input logic [11:0] addr);
        regIndex = (addr[1:0] == 2'h0) ? addr[11:2] : 10'h3ff;
    endfunction

    function automatic logic isMapped(input logic [11:0] addr);
        isMapped = (regIndex(addr) == `WDT_IDX_CONTROL) || (regIndex(addr) == `WDT_IDX_STATUS);
    endfunction

    control_word_t control_reg;
    control_word_t syncedControl_reg;
    logic lock_reg;
    logic busy_reg;
    logic [1:0] syncTicks_reg;
    logic bootPending_reg;
    restart_state_t restartState_reg;
    logic [1:0] restartTicks_reg;
    logic restartSynced_reg;
    logic [31:0] prdata_reg;

    logic setupPhase;
    logic accessPhase;
    logic writeControl;
    logic writeStatus;
    logic controlAccepted;
    logic syncDone;
    logic restartDone;
    logic periodReserved;
    logic windowReserved;
    logic [7:0] statusWord;
    timeout_code_t codes [2];
    logic codeEnabled [2];
    logic codeIsReserved [2];
    timeout_cycles_t codeCycles [2];

    assign setupPhase = psel && !penable;
    assign accessPhase = psel && penable;
    assign writeControl = accessPhase && pwrite && (regIndex(paddr) == `WDT_IDX_CONTROL);
    assign writeStatus = accessPhase && pwrite && (regIndex(paddr) == `WDT_IDX_STATUS);
    // The control register takes a write only when unlocked and inside the unlock window
    assign controlAccepted = writeControl && ccpUnlock && !lock_reg && !bootPending_reg; // R5 R14
    assign syncDone = busy_reg && wdtTick && (syncTicks_reg == `WDT_SYNC_TICKS - 2'h1);
    assign restartDone = (restartState_reg == RESTART_SYNC) && wdtTick
        && (restartTicks_reg == `WDT_RESTART_TICKS - 2'h1);

    // Zero wait states; unmapped or misaligned addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = accessPhase && !isMapped(paddr);
    assign prdata = prdata_reg;

    always_comb begin
        statusWord = '0; // R17
        statusWord[`WDT_LOCK_BIT] = lock_reg; // R4
        statusWord[`WDT_BUSY_BIT] = busy_reg; // R4 R12
    end

    // Read data is captured in the setup cycle so it leaves a flip-flop in the access phase
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata_reg <= '0;
        end else if (setupPhase && !pwrite) begin
            if (regIndex(paddr) == `WDT_IDX_CONTROL) begin
                prdata_reg <= {24'h000000, control_reg};
            end else if (regIndex(paddr) == `WDT_IDX_STATUS) begin
                prdata_reg <= {24'h000000, statusWord}; // R12
            end else begin
                prdata_reg <= '0;
            end
        end
    end

    // The boot configuration is taken in the first cycle after reset release, never at reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bootPending_reg <= 1'b1;
        end else begin
            bootPending_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            control_reg <= `WDT_CONTROL_RESET;
        end else if (bootPending_reg) begin
            control_reg <= bootControl;
        end else if (controlAccepted) begin
            control_reg <= pwdata[7:0]; // R5 R14
        end
    end

    // Lock: boot set first, then a protected set, then a debug-mode clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lock_reg <= 1'(`WDT_STATUS_RESET >> `WDT_LOCK_BIT); // R4
        end else if (bootPending_reg) begin
            lock_reg <= (bootControl[`WDT_PERIOD_MSB:`WDT_PERIOD_LSB] != `WDT_CODE_OFF); // R8
        end else if (writeStatus && ccpUnlock) begin // R9 R14
            if (pwdata[`WDT_LOCK_BIT]) begin
                lock_reg <= 1'b1; // R6
            end else if (debugMode) begin
                lock_reg <= 1'b0; // R7
            end
        end
    end

    // Busy follows an accepted control write until enough watchdog ticks have passed.
    // A fresh write restarts the count, so the newer value is never cut short.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy_reg <= 1'b0; // R4
            syncTicks_reg <= 2'h0;
        end else if (controlAccepted) begin
            busy_reg <= 1'b1; // R10
            syncTicks_reg <= 2'h0;
        end else if (syncDone) begin
            busy_reg <= 1'b0; // R11
            syncTicks_reg <= 2'h0;
        end else if (busy_reg && wdtTick) begin
            syncTicks_reg <= syncTicks_reg + 2'h1;
        end
    end

    // Apart from the boot value, the watchdog side sees a control value only once its crossing has completed
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            syncedControl_reg <= `WDT_CONTROL_RESET;
        end else if (bootPending_reg) begin
            syncedControl_reg <= bootControl;
        end else if (syncDone) begin
            syncedControl_reg <= control_reg; // R10 R11
        end
    end

    // Restart synchronisation; a request between ticks adds up to one period, giving one to two
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            restartState_reg <= RESTART_IDLE;
            restartTicks_reg <= 2'h0;
            restartSynced_reg <= 1'b0;
        end else begin
            restartSynced_reg <= 1'b0;
            case (restartState_reg)
                RESTART_IDLE: begin
                    if (restartReq) begin
                        restartState_reg <= RESTART_SYNC; // R15
                        restartTicks_reg <= 2'h0;
                    end
                end
                RESTART_SYNC: begin
                    // Requests arriving here are dropped on purpose
                    if (restartDone) begin
                        restartState_reg <= RESTART_IDLE; // R15
                        restartTicks_reg <= 2'h0;
                        restartSynced_reg <= 1'b1;
                    end else if (wdtTick) begin
                        restartTicks_reg <= restartTicks_reg + 2'h1;
                    end
                end
                default: begin
                    restartState_reg <= RESTART_IDLE;
                    restartTicks_reg <= 2'h0;
                end
            endcase
        end
    end

    assign codes[0] = syncedControl_reg[`WDT_PERIOD_MSB:`WDT_PERIOD_LSB];
    assign codes[1] = syncedControl_reg[`WDT_WINDOW_MSB:`WDT_WINDOW_LSB];

    // Period and window share one code table
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : gen_decode
            wdt_timeout_decode u_decode (
                .code(codes[gi]),
                .enabled(codeEnabled[gi]),
                .reserved(codeIsReserved[gi]),
                .cycles(codeCycles[gi])
            );
        end
    endgenerate

    assign periodReserved = codeIsReserved[0];
    assign windowReserved = codeIsReserved[1];

    assign activePeriod = codes[0];
    assign activeWindow = codes[1];
    assign periodCycles = codeCycles[0];
    assign windowCycles = codeCycles[1];
    assign watchdogEnabled = codeEnabled[0]; // R16
    assign windowModeEnabled = codeEnabled[1]; // R16
    assign codeReserved = periodReserved || windowReserved; // R3
    assign configLocked = lock_reg;
    assign sync_in_progress_flag = busy_reg;
    assign restartSynced = restartSynced_reg;
endmodule // watchdog_lock_sync_status

`default_nettype wire

// File: watchdog_lock_sync_defines.svh
// Offsets, field positions, reset values and timing counts of the watchdog lock/sync block.
// Included by the status module and the time-out decoder; holds definitions only.
`ifndef WATCHDOG_LOCK_SYNC_DEFINES_SVH
`define WATCHDOG_LOCK_SYNC_DEFINES_SVH

// Register indices; the APB byte address is four times the index
`define WDT_IDX_CONTROL 10'h000
`define WDT_IDX_STATUS 10'h001

// Control register fields
`define WDT_PERIOD_LSB 0
`define WDT_PERIOD_MSB 3
`define WDT_WINDOW_LSB 4
`define WDT_WINDOW_MSB 7

// Status register fields
`define WDT_LOCK_BIT 7
`define WDT_BUSY_BIT 0

// Reset values
`define WDT_CONTROL_RESET 8'h00
`define WDT_STATUS_RESET 8'h00

// Time-out code table: code 1 is 8 watchdog clocks, each further code doubles it
`define WDT_CODE_OFF 4'h0
`define WDT_CODE_FIRST 4'h1
`define WDT_CODE_LAST 4'hb
`define WDT_BASE_CYCLES 14'h0008

// Watchdog clock ticks needed to carry a control write or a restart across
`define WDT_SYNC_TICKS 2'h2
`define WDT_RESTART_TICKS 2'h2

`endif

// File: watchdog_lock_sync_pkg.sv
// Types shared by the watchdog lock/sync block and its time-out decoder.
// Assumes the defines header sits in the same folder.
package watchdog_lock_sync_pkg;
    typedef logic [3:0] timeout_code_t;
    typedef logic [13:0] timeout_cycles_t;
    typedef logic [7:0] control_word_t;
    typedef enum logic {
        RESTART_IDLE,
        RESTART_SYNC
    } restart_state_t;
endpackage

// File: wdt_timeout_decode.sv
// Decodes one four-bit time-out code into a count of watchdog clock periods.
// Assumes the code is stable while the count is used; reserved codes give zero.
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_lock_sync_defines.svh"

module wdt_timeout_decode (
    input wire watchdog_lock_sync_pkg::timeout_code_t code,
    output logic enabled,
    output logic reserved,
    output watchdog_lock_sync_pkg::timeout_cycles_t cycles
);
    import watchdog_lock_sync_pkg::*;

    logic [3:0] shiftAmount;

    always_comb begin
        shiftAmount = code - `WDT_CODE_FIRST;
        enabled = 1'b0;
        reserved = 1'b0;
        cycles = '0;
        if (code == `WDT_CODE_OFF) begin
            enabled = 1'b0;
        end else if (code <= `WDT_CODE_LAST) begin
            enabled = 1'b1; // R16
            cycles = `WDT_BASE_CYCLES << shiftAmount; // R1 R2
        end else begin
            // Undefined encodings are flagged and never start a time-out
            reserved = 1'b1; // R3
        end
    end
endmodule // wdt_timeout_decode

`default_nettype wire

// File: wdt_lock_checker.sv
// Assertions on the watchdog lock/sync block, bound to its top module.
// Assumes wdtTick is a one-cycle enable in the clk_sys domain.
`timescale 1ns/1ps
`default_nettype none
module wdt_lock_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic wdtTick,
    input wire logic ccpUnlock,
    input wire logic debugMode,
    input wire watchdog_lock_sync_pkg::control_word_t bootControl,
    input wire watchdog_lock_sync_pkg::timeout_code_t activePeriod,
    input wire watchdog_lock_sync_pkg::timeout_code_t activeWindow,
    input wire watchdog_lock_sync_pkg::timeout_cycles_t periodCycles,
    input wire watchdog_lock_sync_pkg::timeout_cycles_t windowCycles,
    input wire logic watchdogEnabled,
    input wire logic codeReserved,
    input wire logic configLocked,
    input wire logic sync_in_progress_flag,
    input wire logic restartSynced
);
    import watchdog_lock_sync_pkg::*;
    logic booted;
    wire logic ctrlWr = psel && penable && pwrite && paddr == 12'h000;
    // The first edge after reset loads the boot value, so lock rules start after it
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            booted <= 1'b0;
        end else begin
            booted <= 1'b1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    chk_lock_sticky: assert property (configLocked && !debugMode |=> configLocked)
        else $error("lock cleared outside debug");
    chk_lock_needs_key: assert property (booted && !ccpUnlock |=> !$rose(configLocked))
        else $error("lock set without unlock");
    chk_lock_clear_dbg: assert property ($fell(configLocked) |-> $past(debugMode))
        else $error("lock cleared without debug");
    chk_boot_lock: assert property (!booted |=> configLocked ==
        (($past(bootControl) & 8'h0f) != 8'h00)) else $error("boot lock wrong");
    chk_busy_raise: assert property (booted && ctrlWr && ccpUnlock && !configLocked
        |=> sync_in_progress_flag) else $error("busy not raised");
    chk_busy_holds: assert property (sync_in_progress_flag && !wdtTick |=> sync_in_progress_flag)
        else $error("busy dropped without tick");
    chk_locked_stable: assert property (configLocked && !sync_in_progress_flag
        |=> $stable(activePeriod) && $stable(activeWindow)) else $error("locked config moved");
    chk_code_256: assert property (activePeriod == 4'h6 |-> periodCycles == 14'h0100)
        else $error("code 6 decode wrong");
    chk_code_8k: assert property (activeWindow == 4'hb |-> windowCycles == 14'h2000)
        else $error("code b decode wrong");
    chk_code_reserved: assert property (activePeriod > 4'hb
        |-> codeReserved && !watchdogEnabled && periodCycles == 14'h0000)
        else $error("reserved code decoded");
    chk_restart_pulse: assert property (restartSynced |=> !restartSynced)
        else $error("restart pulse too long");
    cov_lock_set: cover property ($rose(configLocked));
    cov_busy_drop: cover property ($fell(sync_in_progress_flag));
    cov_restart: cover property (restartSynced);
endmodule // wdt_lock_checker

bind watchdog_lock_sync_status wdt_lock_checker chk (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .wdtTick(wdtTick), .ccpUnlock(ccpUnlock), .debugMode(debugMode),
    .bootControl(bootControl), .activePeriod(activePeriod), .activeWindow(activeWindow),
    .periodCycles(periodCycles), .windowCycles(windowCycles),
    .watchdogEnabled(watchdogEnabled), .codeReserved(codeReserved),
    .configLocked(configLocked), .sync_in_progress_flag(sync_in_progress_flag), .restartSynced(restartSynced)
);
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the watchdog lock/sync block over APB.
// Assumes zero-wait APB answers and wdtTick as a one-cycle enable.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import watchdog_lock_sync_pkg::*;
    typedef struct {logic [3:0] code; logic [13:0] cyc; logic en;} row_t;
    logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, wdtTick = 0;
    logic ccpUnlock = 0, debugMode = 0, restartReq = 0, pready, pslverr;
    logic wdEn, winEn, resvd, synced, lockOut, busyOut;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic [7:0] rd;
    control_word_t bootControl = 8'h00;
    timeout_code_t perCode;
    timeout_cycles_t perCyc, winCyc;
    int errTotal = 0, cmpCount = 0, cycles = 0, pulses = 0;
    row_t rows[8] = '{'{4'h6, 14'h0100, 1'b1}, '{4'h7, 14'h0200, 1'b1},
        '{4'h8, 14'h0400, 1'b1}, '{4'h9, 14'h0800, 1'b1}, '{4'ha, 14'h1000, 1'b1},
        '{4'hb, 14'h2000, 1'b1}, '{4'hc, 14'h0000, 1'b0}, '{4'hf, 14'h0000, 1'b0}};

    watchdog_lock_sync_status DUT (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wdtTick(wdtTick), .ccpUnlock(ccpUnlock), .debugMode(debugMode),
        .bootControl(bootControl), .restartReq(restartReq), .activePeriod(perCode),
        .activeWindow(), .periodCycles(perCyc), .windowCycles(winCyc),
        .watchdogEnabled(wdEn), .windowModeEnabled(winEn), .codeReserved(resvd),
        .configLocked(lockOut), .sync_in_progress_flag(busyOut), .restartSynced(synced)
    );

    always #4 clk_sys = ~clk_sys;

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmpCount, errTotal);
        if (errTotal == 0 && cmpCount > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Ceiling well above the few hundred cycles the sequence needs
    always @(posedge clk_sys) begin
        cycles++;
        if (synced === 1'b1) pulses++;
        if (cycles == 3000) begin
            errTotal++;
            complete_run();
        end
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errTotal++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata[7:0];
        chk("pslverr", pslverr, a > 12'h004);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            wdtTick <= 1'b1;
            @(posedge clk_sys);
            wdtTick <= 1'b0;
            repeat (2) @(posedge clk_sys);
        end
    endtask

    task automatic reset_dut();
        rst <= 1'b1;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask

    initial begin
        reset_dut();
        apb(0, 12'h004, 8'h00);
        chk("status reset", rd, 8'h00);
        ccpUnlock <= 1'b1;
        foreach (rows[i]) begin
            apb(1, 12'h000, {rows[i].code, rows[i].code});
            apb(0, 12'h004, 8'h00);
            chk("busy set", rd, 8'h01);
            chk("busy output", busyOut, 1'b1);
            // Next control write only once busy has dropped
            tick(2);
            chk("busy output clear", busyOut, 1'b0);
            apb(0, 12'h004, 8'h00);
            chk("busy clear", rd, 8'h00);
            chk("period cycles", perCyc, rows[i].cyc);
            chk("window cycles", winCyc, rows[i].cyc);
            chk("decode flags", {wdEn, winEn, resvd}, {rows[i].en, rows[i].en, !rows[i].en});
        end
        apb(1, 12'h004, 8'h7f);
        apb(0, 12'h004, 8'h00);
        chk("status reserved", rd, 8'h00);
        ccpUnlock <= 1'b0;
        apb(1, 12'h004, 8'h80);
        apb(0, 12'h004, 8'h00);
        chk("lock no key", rd, 8'h00);
        ccpUnlock <= 1'b1;
        apb(1, 12'h004, 8'h80);
        apb(1, 12'h000, 8'h21);
        apb(0, 12'h004, 8'h00);
        chk("lock set", rd, 8'h80);
        chk("lock output", lockOut, 1'b1);
        apb(0, 12'h000, 8'h00);
        chk("control locked", rd, 8'hff);
        apb(1, 12'h004, 8'h00);
        apb(0, 12'h004, 8'h00);
        chk("lock kept", rd, 8'h80);
        debugMode <= 1'b1;
        apb(1, 12'h004, 8'h00);
        debugMode <= 1'b0;
        apb(0, 12'h004, 8'h00);
        chk("lock debug clear", rd, 8'h00);
        apb(0, 12'h008, 8'h00);
        chk("unmapped read", rd, 8'h00);
        restartReq <= 1'b1;
        @(posedge clk_sys);
        restartReq <= 1'b0;
        tick(1);
        // Second request lands while the first is still crossing
        restartReq <= 1'b1;
        @(posedge clk_sys);
        restartReq <= 1'b0;
        tick(1);
        chk("restart first", pulses[15:0], 16'h0001);
        tick(2);
        chk("restart ignored", pulses[15:0], 16'h0001);
        bootControl <= 8'h35;
        reset_dut();
        apb(0, 12'h004, 8'h00);
        chk("boot lock", rd, 8'h80);
        chk("boot period", perCode, 4'h5);
        chk("boot enables", {wdEn, winEn}, 2'b11);
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
